// file: rtl/spi_fe_cfg.svh
`ifndef SPI_FE_CFG_SVH
`define SPI_FE_CFG_SVH

// Core clock rate and internal write cycle time
`define CORE_CLK_HZ 20000000
`define WC_TIME_MS 5
`define WC_CYCLES ((`WC_TIME_MS * `CORE_CLK_HZ) / 1000)
`define TIMER_W 17

// Serial framing
`define BIT_CNT_W 3
`define BIT_LAST 3'h0
`define BIT_FIRST 3'h1
`define WR_MIN_BYTES 2'h3

// Reset values
`define CS_IDLE 1'h1
`define OE_N_OFF 1'h1

`endif

// file: rtl/spi_fe_pkg.sv
package spi_fe_pkg;

    // One serial byte
    typedef logic [7:0] byte_t;

    // Internal write cycle engine
    typedef enum logic {
        WR_IDLE,
        WR_BUSY
    } wr_state_t;

endpackage

// file: rtl/two_entry_buffer.sv
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    logic [WIDTH-1:0] outData_q, outData_d, skidData_q, skidData_d;
    logic outValid_q, outValid_d, skidValid_q, skidValid_d, inReady_q;
    wire pushOk = inValid && inReady_q;
    wire outFree = !outValid_q || outReady;

    // Output stage refills from the skid entry first, keeping order
    always_comb begin
        outData_d = outData_q;
        outValid_d = outValid_q;
        skidData_d = skidData_q;
        skidValid_d = skidValid_q;
        if (outFree) begin
            if (skidValid_q) begin
                outData_d = skidData_q;
                outValid_d = 1'h1;
                skidValid_d = pushOk;
                skidData_d = inData;
            end else begin
                outData_d = inData;
                outValid_d = pushOk;
            end
        end else if (pushOk) begin
            skidData_d = inData;
            skidValid_d = 1'h1;
        end
    end

    // Ready is registered so the source sees a clean stall
    always_ff @(posedge clk) begin
        if (rst) begin
            outValid_q <= 1'h0;
            skidValid_q <= 1'h0;
            inReady_q <= 1'h0;
            outData_q <= '0;
            skidData_q <= '0;
        end else begin
            outValid_q <= outValid_d;
            skidValid_q <= skidValid_d;
            inReady_q <= !skidValid_d;
            outData_q <= outData_d;
            skidData_q <= skidData_d;
        end
    end

    assign inReady = inReady_q;
    assign outData = outData_q;
    assign outValid = outValid_q;

endmodule

// file: rtl/spi_eeprom_pin_front_end.sv
// Function
// - Chip select low selects the device; high deselects it into standby.
// - A started write cycle always runs to completion whatever chip select does.
// - Standby after deselect waits until a running write cycle has finished.
// - Serial output floats as soon as the device is deselected.
// - Chip select rising after a complete valid write sequence starts the write if no write cycle is running.
// - After power-up nothing counts until chip select has gone high and then low again.
// - Serial input bits are captured on each rising serial clock edge while hold is not in effect.
// - While selected, serial output changes only after a falling serial clock edge.
// - The internal write cycle ends within five milliseconds.
// - Hold low floats the output; releasing hold resumes driving valid data.
// - Every byte moves most significant bit first in both directions.
// - Hold changes take effect at a falling serial clock edge.
// - Chip select rising off a byte boundary aborts the write.
`include "spi_fe_cfg.svh"

module spi_eeprom_pin_front_end
    import spi_fe_pkg::*;
#(
    parameter int WC_CYCLES = `WC_CYCLES
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Serial pins
    input wire logic sckClk,
    input wire logic csN,
    input wire logic si,
    input wire logic holdN,
    output logic soOut,
    output logic soOeN,
    // Received bytes
    output byte_t rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxOverrun,
    // Read data to shift out
    input wire byte_t txByte,
    input wire logic txValid,
    output logic txReady,
    // Write cycle control
    input wire logic writeSeqValid,
    output logic writeBusy,
    output logic writeStart,
    output logic writeAbort,
    output logic writeDone,
    // Select state
    output logic selected,
    output logic standby
);

    // Link domain, clocked by the serial clock
    logic fresh_q;
    logic [`BIT_CNT_W-1:0] bitCnt_q;
    byte_t rxShift_q, rxWord_q;
    logic rxTgl_q, aligned_q;
    logic holdAct_q, driving_q, soOeN_q, soData_q;
    logic [6:0] txShift_q;
    logic txMeta_q, txSync_q, txAck_q;
    // Read byte and its toggle live in the core domain, declared here for the link logic
    byte_t txHold_q;
    logic txTgl_q;

    // Deselect or system reset clears the frame state at once
    wire frameRst = csN || sys_rst;
    wire [`BIT_CNT_W-1:0] bitNext = fresh_q ? `BIT_FIRST : bitCnt_q + `BIT_CNT_W'(1);
    wire byteEnd = (bitNext == `BIT_LAST);
    byte_t rxFull;
    assign rxFull = {rxShift_q[6:0], si};

    // First edge of a frame restarts the bit count
    always_ff @(posedge sckClk or posedge frameRst) begin
        if (frameRst) begin
            fresh_q <= 1'h1;
        end else if (!holdAct_q) begin
            fresh_q <= 1'h0;
        end
    end

    // Input shifts in on the rising edge, paused while held
    always_ff @(posedge sckClk or posedge sys_rst) begin
        if (sys_rst) begin
            bitCnt_q <= `BIT_LAST;
            rxShift_q <= '0;
            rxWord_q <= '0;
            rxTgl_q <= 1'h0;
            aligned_q <= 1'h1;
        end else if (!holdAct_q) begin
            bitCnt_q <= bitNext;
            rxShift_q <= rxFull;
            aligned_q <= byteEnd;
            if (byteEnd) begin
                rxWord_q <= rxFull;
                rxTgl_q <= !rxTgl_q;
            end
        end
    end

    // Link-side view of read data hand-off
    wire holdNow = !holdN;
    wire txPend = (txSync_q != txAck_q);
    wire loadNow = (bitCnt_q == `BIT_LAST) && !fresh_q;
    wire loadTake = !holdNow && loadNow && txPend;
    wire drvNext = loadNow ? loadTake : driving_q;

    // Output moves on the falling edge; hold sampled here too
    always_ff @(negedge sckClk or posedge frameRst) begin
        if (frameRst) begin
            holdAct_q <= 1'h0;
            driving_q <= 1'h0;
            soOeN_q <= `OE_N_OFF;
            soData_q <= 1'h0;
            txShift_q <= '0;
        end else if (holdNow) begin
            holdAct_q <= 1'h1;
            soOeN_q <= `OE_N_OFF;
        end else begin
            holdAct_q <= 1'h0;
            driving_q <= drvNext;
            soOeN_q <= !drvNext;
            if (loadTake) begin
                soData_q <= txHold_q[7];
                txShift_q <= txHold_q[6:0];
            end else if (!loadNow && driving_q) begin
                soData_q <= txShift_q[6];
                txShift_q <= {txShift_q[5:0], 1'h0};
            end
        end
    end

    // Hand-off toggle crosses in; acknowledge goes back out
    always_ff @(negedge sckClk or posedge sys_rst) begin
        if (sys_rst) begin
            txMeta_q <= 1'h0;
            txSync_q <= 1'h0;
            txAck_q <= 1'h0;
        end else begin
            txMeta_q <= txTgl_q;
            txSync_q <= txMeta_q;
            if (loadTake) begin
                txAck_q <= !txAck_q;
            end
        end
    end

    assign soOut = soData_q;
    assign soOeN = soOeN_q;

    // Core domain
    logic csMeta_q, csSync_q, csPrev_q;
    logic rxMeta_q, rxSync_q, rxPrev_q;
    logic alMeta_q, alSync_q;
    logic ackMeta_q, ackSync_q;
    logic frameOk_q, rxPend_q, overrun_q;
    byte_t rxHoldData_q;
    logic txReady_q;
    logic [1:0] byteCnt_q;
    wr_state_t wrState_q, wrState_d;
    logic [`TIMER_W-1:0] timer_q;
    logic startP_q, abortP_q, doneP_q, standby_q, busy_q;
    logic bufReady;

    // Pin and cross-domain levels pass two flops before use
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            csMeta_q <= 1'h0;
            csSync_q <= 1'h0;
            csPrev_q <= 1'h0;
            rxMeta_q <= 1'h0;
            rxSync_q <= 1'h0;
            rxPrev_q <= 1'h0;
            alMeta_q <= 1'h1;
            alSync_q <= 1'h1;
            ackMeta_q <= 1'h0;
            ackSync_q <= 1'h0;
        end else begin
            csMeta_q <= csN;
            csSync_q <= csMeta_q;
            csPrev_q <= csSync_q;
            rxMeta_q <= rxTgl_q;
            rxSync_q <= rxMeta_q;
            rxPrev_q <= rxSync_q;
            alMeta_q <= aligned_q;
            alSync_q <= alMeta_q;
            ackMeta_q <= txAck_q;
            ackSync_q <= ackMeta_q;
        end
    end

    // Chip select edges; sync starts low so a frame open at reset is never counted
    wire csFall = csPrev_q && !csSync_q;
    wire csRise = !csPrev_q && csSync_q;
    wire frameOk_d = csFall ? 1'h1 : (csRise ? 1'h0 : frameOk_q);
    wire rxEdge = rxSync_q ^ rxPrev_q;
    wire rxTake = rxEdge && frameOk_q;
    wire seqWhole = (byteCnt_q == `WR_MIN_BYTES) && alSync_q;
    wire wrIdle = (wrState_q == WR_IDLE);
    wire launch = csRise && frameOk_q && writeSeqValid && seqWhole && wrIdle;
    wire abort = csRise && frameOk_q && writeSeqValid && !seqWhole;
    wire timerEnd = (timer_q == `TIMER_W'(1));
    wire txAccept = txValid && txReady_q;
    wire txTgl_d = txAccept ? !txTgl_q : txTgl_q;

    // Write engine keeps going once launched, chip select is not looked at
    always_comb begin
        wrState_d = wrState_q;
        case (wrState_q)
            WR_IDLE: begin
                if (launch) begin
                    wrState_d = WR_BUSY;
                end
            end
            WR_BUSY: begin
                if (timerEnd) begin
                    wrState_d = WR_IDLE;
                end
            end
            default: begin
                wrState_d = WR_IDLE;
            end
        endcase
    end

    // Frame bookkeeping and write timer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frameOk_q <= 1'h0;
            byteCnt_q <= 2'h0;
            wrState_q <= WR_IDLE;
            timer_q <= '0;
            startP_q <= 1'h0;
            abortP_q <= 1'h0;
            doneP_q <= 1'h0;
            standby_q <= 1'h1;
            busy_q <= 1'h0;
        end else begin
            frameOk_q <= frameOk_d;
            if (csFall) begin
                byteCnt_q <= 2'h0;
            end else if (rxTake && byteCnt_q != `WR_MIN_BYTES) begin
                byteCnt_q <= byteCnt_q + 2'h1;
            end
            wrState_q <= wrState_d;
            if (launch) begin
                timer_q <= `TIMER_W'(WC_CYCLES);
            end else if (!wrIdle) begin
                timer_q <= timer_q - `TIMER_W'(1);
            end
            startP_q <= launch;
            abortP_q <= abort;
            doneP_q <= !wrIdle && timerEnd;
            standby_q <= !frameOk_d && (wrState_d == WR_IDLE);
            busy_q <= (wrState_d == WR_BUSY);
        end
    end

    // Received byte waits here if the buffer is stalled; set beats clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxPend_q <= 1'h0;
            rxHoldData_q <= '0;
            overrun_q <= 1'h0;
        end else begin
            rxPend_q <= rxTake || (rxPend_q && !bufReady);
            if (rxTake) begin
                rxHoldData_q <= rxWord_q;
            end
            if (rxTake && rxPend_q && !bufReady) begin
                overrun_q <= 1'h1;
            end else if (csFall) begin
                overrun_q <= 1'h0;
            end
        end
    end

    // Read data handed across; held stable until acknowledged
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            txHold_q <= '0;
            txTgl_q <= 1'h0;
            txReady_q <= 1'h0;
        end else begin
            if (txAccept) begin
                txHold_q <= txByte;
            end
            txTgl_q <= txTgl_d;
            txReady_q <= (txTgl_d == ackSync_q);
        end
    end

    two_entry_buffer #(
        .WIDTH(8)
    ) rxBuf (
        .clk(core_clk),
        .rst(sys_rst),
        .inData(rxHoldData_q),
        .inValid(rxPend_q),
        .inReady(bufReady),
        .outData(rxData),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    assign rxOverrun = overrun_q;
    assign txReady = txReady_q;
    assign writeBusy = busy_q;
    assign writeStart = startP_q;
    assign writeAbort = abortP_q;
    assign writeDone = doneP_q;
    assign selected = frameOk_q;
    assign standby = standby_q;

    // Checks in the core domain
    chk_standby_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
        !wrIdle && !timerEnd |=> !standby_q)
        else $error("standby entered during write cycle");
    chk_busy_persists: assert property (@(posedge core_clk) disable iff (sys_rst)
        !wrIdle && !timerEnd && $changed(csSync_q) |=> !wrIdle)
        else $error("write cycle cut short by chip select");
    chk_write_launch: assert property (@(posedge core_clk) disable iff (sys_rst)
        launch |=> writeStart && writeBusy && timer_q == `TIMER_W'(WC_CYCLES))
        else $error("valid write sequence did not launch a write");
    chk_write_abort: assert property (@(posedge core_clk) disable iff (sys_rst)
        csRise && !alSync_q |=> !writeStart && !$rose(writeBusy))
        else $error("write launched off a byte boundary");
    chk_frame_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        rxEdge && !frameOk_q && !rxPend_q |=> !rxPend_q)
        else $error("byte taken outside an accepted frame");
    chk_write_ends: assert property (@(posedge core_clk) disable iff (sys_rst)
        !wrIdle && timerEnd |=> wrIdle && writeDone)
        else $error("write cycle overran its timer");
    chk_deselect_float: assert property (@(posedge core_clk) disable iff (sys_rst)
        csSync_q |-> soOeN_q)
        else $error("output driven while deselected");

    // Checks in the link domain
    chk_msb_first: assert property (@(posedge sckClk) disable iff (frameRst)
        !holdAct_q && byteEnd |=> rxWord_q == {$past(rxShift_q[6:0]), $past(si)})
        else $error("received byte not assembled msb first");
    chk_hold_float: assert property (@(negedge sckClk) disable iff (frameRst)
        holdNow |=> soOeN_q || !holdN)
        else $error("output driven while held");
    chk_drive_gate: assert property (@(negedge sckClk) disable iff (frameRst)
        !soOeN_q |-> driving_q && !holdAct_q)
        else $error("output driven outside read data phase");
    chk_load_msb: assert property (@(negedge sckClk) disable iff (frameRst)
        loadTake |=> soData_q == $past(txHold_q[7]) && !soOeN_q)
        else $error("read byte did not start with its top bit");

endmodule

// file: testbench/spi_master_model.sv
module spi_master_model
    import spi_fe_pkg::*;
(
    // Serial pins towards the device
    output logic sckClk,
    output logic csN,
    output logic si,
    output logic holdN,
    // Serial output from the device
    input wire logic soOut,
    input wire logic soOeN
);
    timeunit 1ns;
    timeprecision 1ns;

    logic lastSo;

    // Clock stands low outside frames; select low through power-up
    initial begin
        sckClk = 1'b0;
        csN = 1'b0; // Deliberately low before any high is seen
        si = 1'b0;
        holdN = 1'b1;
        lastSo = 1'b0;
    end

    task automatic csLow();
        #40 csN = 1'b0;
        #40;
    endtask

    // Idle time covers the device's select synchroniser
    task automatic csHigh();
        #40 csN = 1'b1; // Raised off a byte boundary only when aborting
        #300;
    endtask

    // Shift n bits MSB first, optionally pausing after bit holdAt
    task automatic xfer(input byte_t tx, input int n, input int holdAt,
                        output byte_t rx, output logic oeLast, output logic oeHeld);
        rx = 8'h00;
        oeLast = 1'b1;
        oeHeld = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = tx[7-i];
            #32 sckClk = 1'b1;
            // A floating line reads as the inverse of its last value
            lastSo = soOeN ? ~lastSo : soOut;
            rx = {rx[6:0], lastSo};
            oeLast = soOeN;
            if (i == holdAt) begin
                holdN = 1'b0; // Lowered with clock high: effective at next fall
                #32 sckClk = 1'b0;
                si = ~si;
                #32 sckClk = 1'b1;
                oeHeld = soOeN;
                #32 sckClk = 1'b0;
                #16 holdN = 1'b1; // Released with the clock low
                #16 sckClk = 1'b1;
            end
            #32 sckClk = 1'b0;
        end
    endtask
endmodule

// file: testbench/spi_eeprom_pin_front_end_tb_top.sv
module spi_eeprom_pin_front_end_tb_top
    import spi_fe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int WC = 60;

    logic core_clk = 1'b0;
    logic sys_rst, rxReady, txValid, writeSeqValid;
    logic sckClk, csN, si, holdN, soOut, soOeN, rxValid, rxOverrun, txReady;
    logic writeBusy, writeStart, writeAbort, writeDone, selected, standby;
    logic oeL, oeH;
    byte_t txByte, rxData, rx;
    int errCount = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int starts = 0;
    int aborts = 0;
    int startCyc = 0;
    int doneCyc = 0;

    spi_eeprom_pin_front_end #(.WC_CYCLES(WC)) i_spi_eeprom_pin_front_end (
        .core_clk(core_clk), .sys_rst(sys_rst), .sckClk(sckClk), .csN(csN), .si(si),
        .holdN(holdN), .soOut(soOut), .soOeN(soOeN), .rxData(rxData), .rxValid(rxValid),
        .rxReady(rxReady), .rxOverrun(rxOverrun), .txByte(txByte), .txValid(txValid),
        .txReady(txReady), .writeSeqValid(writeSeqValid), .writeBusy(writeBusy),
        .writeStart(writeStart), .writeAbort(writeAbort), .writeDone(writeDone),
        .selected(selected), .standby(standby));

    spi_master_model i_spi_master_model (
        .sckClk(sckClk), .csN(csN), .si(si), .holdN(holdN), .soOut(soOut), .soOeN(soOeN));

    always #25 core_clk = ~core_clk;

    // Pulse bookkeeping and hang guard; falling edge so pulses are settled
    always @(negedge core_clk) begin
        cycles++;
        if (writeStart === 1'b1) begin
            starts++;
            startCyc = cycles;
        end
        if (writeDone === 1'b1) begin
            doneCyc = cycles;
        end
        if (writeAbort === 1'b1) begin
            aborts++;
        end
        if (cycles == 20000) begin
            errCount++;
            tallyAndFinish();
        end
    end

    task automatic tallyAndFinish();
        $display("Checks %0d, mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic checkBit(string what, logic exp, logic got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic checkByte(string what, byte_t exp, byte_t got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkCount(string what, int exp, int got);
        samplesChecked++;
        if (got != exp) begin
            errCount++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic waitCore(int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Holds valid until a cycle in which ready was high has passed
    task automatic pushTx(byte_t b);
        int n;
        n = 0;
        @(negedge core_clk);
        txByte = b;
        txValid = 1'b1;
        while (txReady !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        txValid = 1'b0;
    endtask

    task automatic popRx(output byte_t b);
        int n;
        n = 0;
        @(negedge core_clk);
        while (rxValid !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        b = rxData;
        rxReady = 1'b1;
        @(negedge core_clk);
        rxReady = 1'b0;
    endtask

    task automatic drainRx();
        byte_t b;
        for (int k = 0; k < 6; k++) begin
            waitCore(3);
            if (rxValid === 1'b1) begin
                popRx(b);
            end
        end
    endtask

    task automatic testPowerUp();
        i_spi_master_model.xfer(8'hC3, 8, -1, rx, oeL, oeH);
        waitCore(10);
        checkBit("rxValid", 1'b0, rxValid);
        checkBit("selected", 1'b0, selected);
        i_spi_master_model.csHigh();
        checkBit("soOeN", 1'b1, soOeN);
        checkBit("standby", 1'b1, standby);
        $display("test power-up done");
    endtask

    task automatic testRx();
        byte_t b;
        i_spi_master_model.csLow();
        i_spi_master_model.xfer(8'hA5, 8, -1, rx, oeL, oeH);
        checkBit("selected", 1'b1, selected);
        checkBit("standby", 1'b0, standby);
        i_spi_master_model.xfer(8'h3C, 8, 3, rx, oeL, oeH);
        i_spi_master_model.csHigh();
        popRx(b);
        checkByte("rxData", 8'hA5, b);
        popRx(b);
        checkByte("rxData held", 8'h3C, b);
        checkBit("selected", 1'b0, selected);
        $display("test rx done");
    endtask

    // Receiver stalls until bytes are lost, then drains in order
    task automatic testOverrun();
        byte_t b;
        i_spi_master_model.csLow();
        for (int i = 0; i < 5; i++) begin
            i_spi_master_model.xfer(8'h10 + 8'(i), 8, -1, rx, oeL, oeH);
        end
        i_spi_master_model.csHigh();
        waitCore(10);
        checkBit("rxOverrun", 1'b1, rxOverrun);
        popRx(b);
        checkByte("rxData", 8'h10, b);
        popRx(b);
        checkByte("rxData", 8'h11, b);
        drainRx();
        i_spi_master_model.csLow();
        waitCore(10);
        checkBit("rxOverrun", 1'b0, rxOverrun);
        i_spi_master_model.csHigh();
        $display("test overrun done");
    endtask

    task automatic testRead();
        i_spi_master_model.csLow();
        pushTx(8'hA5);
        i_spi_master_model.xfer(8'h03, 8, -1, rx, oeL, oeH);
        fork
            i_spi_master_model.xfer(8'h00, 8, -1, rx, oeL, oeH);
            pushTx(8'h96);
        join
        checkByte("so byte", 8'hA5, rx);
        checkBit("soOeN", 1'b0, oeL);
        i_spi_master_model.xfer(8'h00, 8, 3, rx, oeL, oeH);
        checkBit("soOeN held", 1'b1, oeH);
        checkBit("soOeN resumed", 1'b0, oeL);
        checkByte("so byte held", 8'h96, rx);
        i_spi_master_model.xfer(8'h00, 8, -1, rx, oeL, oeH);
        checkBit("soOeN no data", 1'b1, oeL);
        i_spi_master_model.csHigh();
        checkBit("soOeN", 1'b1, soOeN);
        drainRx();
        $display("test read done");
    endtask

    // Second write frame lands while the first cycle is still running
    task automatic testWrite();
        int s0;
        s0 = starts;
        writeSeqValid = 1'b1;
        for (int f = 0; f < 2; f++) begin
            i_spi_master_model.csLow();
            i_spi_master_model.xfer(8'h02, 8, -1, rx, oeL, oeH);
            i_spi_master_model.xfer(8'h10, 8, -1, rx, oeL, oeH);
            i_spi_master_model.xfer(8'h5A, 8, -1, rx, oeL, oeH);
            if (f == 1) begin
                checkBit("writeBusy", 1'b1, writeBusy);
            end
            i_spi_master_model.csHigh();
        end
        checkBit("standby busy", 1'b0, standby);
        for (int n = 0; n < 100 && writeBusy === 1'b1; n++) begin
            waitCore(1);
        end
        waitCore(2);
        checkBit("standby", 1'b1, standby);
        checkCount("write cycles", WC, doneCyc - startCyc);
        checkCount("writeStart", s0 + 1, starts);
        drainRx();
        $display("test write done");
    endtask

    task automatic testAbort();
        int s0;
        int a0;
        for (int k = 0; k < 2; k++) begin
            s0 = starts;
            a0 = aborts;
            i_spi_master_model.csLow();
            i_spi_master_model.xfer(8'h02, 8, -1, rx, oeL, oeH);
            i_spi_master_model.xfer(8'h10, 8, -1, rx, oeL, oeH);
            if (k == 0) begin
                i_spi_master_model.xfer(8'h5A, 3, -1, rx, oeL, oeH);
            end
            i_spi_master_model.csHigh();
            waitCore(5);
            checkCount("writeAbort", a0 + 1, aborts);
            checkCount("writeStart", s0, starts);
            drainRx();
        end
        writeSeqValid = 1'b0;
        $display("test abort done");
    endtask

    initial begin
        sys_rst = 1'b1;
        rxReady = 1'b0;
        txValid = 1'b0;
        txByte = 8'h00;
        writeSeqValid = 1'b0;
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        waitCore(4);
        testPowerUp();
        testRx();
        testOverrun();
        testRead();
        testWrite();
        testAbort();
        tallyAndFinish();
    end
endmodule
